/* File: hw/out_route_regs.vh */
`ifndef OUT_ROUTE_REGS_VH
`define OUT_ROUTE_REGS_VH

// register offsets
`define AUX_CLOCK_CONTROL_ADDR    8'h18
`define OUTPUT_ROUTE_CONTROL_ADDR 8'h1B
`define FRAC_SETTING_ADDR         8'h0C

// output route control fields
`define ROUTE_SEL_MSB    3
`define ROUTE_SEL_LSB    0
`define STATIC_VAL_MSB   6
`define STATIC_VAL_LSB   4
`define ROUTE_CTRL_RESET 7'h00

// aux clock control fields
`define AUX_DIV_MSB      6
`define AUX_DIV_LSB      4
`define AUX_DLY_MSB      3
`define AUX_DLY_LSB      2
`define AUX_SRC_MSB      1
`define AUX_SRC_LSB      0
`define AUX_CTRL_RESET   7'h00

// route codes
`define ROUTE_STATIC     4'h0
`define ROUTE_DIVIDERS   4'h1
`define ROUTE_LOCK_WIN   4'h2
`define ROUTE_SLIP       4'h3
`define ROUTE_FRAC_STB   4'h4
`define ROUTE_ACCUM      4'h6
`define ROUTE_AUX_OSC    4'h7
`define ROUTE_MOD_OUT    4'hA

// aux clock sources
`define AUX_SRC_VCO      2'h0
`define AUX_SRC_XTAL     2'h1
`define AUX_SRC_RING     2'h2

`endif

/* File: hw/general_output_route_mux.v */
// Operation
// - route select is route register bits 3:0
// - select zero drives static 3-bit value
// - select one: reference crystal on line three
// - select one: ref divider two, prescaler one
// - select two: lock window, down, up
// - select three: ref-fast, vco-fast, max-gain hold
// - max-gain hold stays until lock achieved
// - fractional write makes synchronized update strobe
// - select four: strobe, ref divider, sine ref
// - select six: accumulator top three bits
// - select seven: aux, ring, modulator clock
// - aux source: vco, crystal, or ring
// - aux divide by even 2 to 14
// - aux delay chosen by bits 3:2
// - select ten: modulator output low bits
`timescale 1ns/1ps
`include "out_route_regs.vh"

module general_output_route_mux #(
	parameter ACC_W = 24, // modulator accumulator width
	parameter MOD_W = 4   // modulator output width
) (
	input  wire             MCLK,           // system clock
	input  wire             RST,            // async reset, high
	input  wire             REG_WR,         // register write strobe
	input  wire [7:0]       REG_ADDR,       // register address
	input  wire [6:0]       REG_WDATA,      // register write data
	input  wire             XTAL_REF,       // buffered crystal reference
	input  wire             SINE_REF,       // sine reference input
	input  wire             REF_DIV_OUT,    // reference divider output
	input  wire             PRESC_OUT,      // prescaler divider output
	input  wire             LOCK_WINDOW,    // lock detect window
	input  wire             PFD_UP,         // phase detector up
	input  wire             PFD_DN,         // phase detector down
	input  wire             REF_FASTER,     // ref above vco frequency
	input  wire             VCO_FASTER,     // vco above ref frequency
	input  wire             MAX_GAIN_HOLD,  // max gain hold, pull-in
	input  wire             LOCKED,         // vco lock achieved
	input  wire [ACC_W-1:0] ACCUM,          // first accumulator
	input  wire [MOD_W-1:0] MOD_OUT,        // modulator output
	input  wire             MOD_CLK,        // modulator clock level
	input  wire             RING_OSC,       // ring oscillator level
	input  wire             VCO_CLK,        // vco-derived clock level
	output reg  [6:0]       ROUTE_CTRL,     // route register readback
	output reg  [6:0]       AUX_CTRL,       // aux register readback
	output reg              FRAC_UPDATE,    // modulator update start pulse
	output reg              OUT_LINE_ONE,   // output line one
	output reg              OUT_LINE_TWO,   // output line two
	output reg              OUT_LINE_THREE  // output line three
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg [6:0] route_reg;
reg [6:0] aux_reg;
reg       frac_wr_reg;
reg       frac_sync_reg;
reg       mod_clk_reg;
reg       hold_reg;

// register writes
always @(posedge MCLK or posedge RST) begin
	if (RST) begin
		route_reg <= `ROUTE_CTRL_RESET;
		aux_reg   <= `AUX_CTRL_RESET;
	end else if (REG_WR) begin
		if (REG_ADDR == `OUTPUT_ROUTE_CONTROL_ADDR) begin
			route_reg <= REG_WDATA;
		end else if (REG_ADDR == `AUX_CLOCK_CONTROL_ADDR) begin
			aux_reg <= REG_WDATA;
		end
	end
end

// readback copies
always @(posedge MCLK or posedge RST) begin
	if (RST) begin
		ROUTE_CTRL <= `ROUTE_CTRL_RESET;
		AUX_CTRL   <= `AUX_CTRL_RESET;
	end else begin
		ROUTE_CTRL <= route_reg;
		AUX_CTRL   <= aux_reg;
	end
end

////////////////////////////////////////////////////////////////////////////////
// fractional update strobe, aligned to modulator clock rising edge
wire mod_rise = MOD_CLK & ~mod_clk_reg;

always @(posedge MCLK or posedge RST) begin
	if (RST) begin
		frac_wr_reg   <= 1'b0;
		frac_sync_reg <= 1'b0;
		mod_clk_reg   <= 1'b0;
		FRAC_UPDATE   <= 1'b0;
	end else begin
		mod_clk_reg <= MOD_CLK;
		// pending write held until next modulator edge; new write wins
		if (REG_WR && REG_ADDR == `FRAC_SETTING_ADDR) begin
			frac_wr_reg <= 1'b1;
		end else if (mod_rise) begin
			frac_wr_reg <= 1'b0;
		end
		frac_sync_reg <= frac_wr_reg & mod_rise;
		FRAC_UPDATE   <= frac_wr_reg & mod_rise;
	end
end

////////////////////////////////////////////////////////////////////////////////
// max gain hold stretched until lock
always @(posedge MCLK or posedge RST) begin
	if (RST) begin
		hold_reg <= 1'b0;
	end else if (MAX_GAIN_HOLD) begin
		hold_reg <= 1'b1;
	end else if (LOCKED) begin
		hold_reg <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// auxiliary clock: source, even divider, delay
wire [1:0] aux_src = aux_reg[`AUX_SRC_MSB:`AUX_SRC_LSB];
wire [2:0] aux_div = aux_reg[`AUX_DIV_MSB:`AUX_DIV_LSB];
wire [1:0] aux_dly = aux_reg[`AUX_DLY_MSB:`AUX_DLY_LSB];
reg        aux_src_clk;
reg        src_prev_reg;
reg  [2:0] div_cnt_reg;
reg        aux_div_reg;
reg  [3:0] dly_line_reg;
reg        aux_clk;

// source select
always @* begin
	case (aux_src)
		`AUX_SRC_VCO:  aux_src_clk = VCO_CLK;
		`AUX_SRC_XTAL: aux_src_clk = XTAL_REF;
		default:       aux_src_clk = RING_OSC;
	endcase
end

// toggle every (div+1) source edges: ratio 2*(div+1), i.e. 2..16 capped at 14
wire [2:0] half_cnt = (aux_div == 3'h7) ? 3'h6 : aux_div;

always @(posedge MCLK or posedge RST) begin
	if (RST) begin
		src_prev_reg <= 1'b0;
		div_cnt_reg  <= 3'h0;
		aux_div_reg  <= 1'b0;
		dly_line_reg <= 4'h0;
	end else begin
		src_prev_reg <= aux_src_clk;
		if (aux_src_clk & ~src_prev_reg) begin
			if (div_cnt_reg >= half_cnt) begin
				div_cnt_reg <= 3'h0;
				aux_div_reg <= ~aux_div_reg;
			end else begin
				div_cnt_reg <= div_cnt_reg + 3'h1;
			end
		end
		dly_line_reg <= {dly_line_reg[2:0], aux_div_reg};
	end
end

// delay tap select
always @* begin
	aux_clk = dly_line_reg[aux_dly];
end

////////////////////////////////////////////////////////////////////////////////
// output route mux
wire [3:0] route_sel  = route_reg[`ROUTE_SEL_MSB:`ROUTE_SEL_LSB];
wire [2:0] static_val = route_reg[`STATIC_VAL_MSB:`STATIC_VAL_LSB];
reg  [2:0] lines_next; // {three, two, one}

always @* begin
	case (route_sel)
		`ROUTE_STATIC:   lines_next = static_val;
		`ROUTE_DIVIDERS: lines_next = {XTAL_REF, REF_DIV_OUT, PRESC_OUT};
		`ROUTE_LOCK_WIN: lines_next = {PFD_UP, PFD_DN, LOCK_WINDOW};
		`ROUTE_SLIP:     lines_next = {REF_FASTER, VCO_FASTER, hold_reg};
		`ROUTE_FRAC_STB: lines_next = {SINE_REF, REF_DIV_OUT, frac_sync_reg};
		`ROUTE_ACCUM:    lines_next = ACCUM[ACC_W-1:ACC_W-3];
		`ROUTE_AUX_OSC:  lines_next = {aux_clk, RING_OSC, MOD_CLK};
		`ROUTE_MOD_OUT:  lines_next = MOD_OUT[2:0];
		default:         lines_next = 3'h0;
	endcase
end

// registered outputs
always @(posedge MCLK or posedge RST) begin
	if (RST) begin
		OUT_LINE_ONE   <= 1'b0;
		OUT_LINE_TWO   <= 1'b0;
		OUT_LINE_THREE <= 1'b0;
	end else begin
		OUT_LINE_ONE   <= lines_next[0];
		OUT_LINE_TWO   <= lines_next[1];
		OUT_LINE_THREE <= lines_next[2];
	end
end

endmodule

/* File: tb/line_probe.sv */
`timescale 1ns/1ps
// instrument watching the three output pins
module line_probe (
	input  wire       line_one,   // pin one
	input  wire       line_two,   // pin two
	input  wire       line_three, // pin three
	output wire [2:0] seen        // pins as a bus
);
	// gather pins, line three on top
	assign seen = {line_three, line_two, line_one};
endmodule

/* File: tb/general_output_route_mux_properties.sv */
`timescale 1ns/1ps
module route_mux_properties (
	input wire       MCLK,           // clock
	input wire       RST,            // reset
	input wire       LOCK_WINDOW,    // lock window
	input wire       PFD_UP,         // pump up
	input wire       PFD_DN,         // pump down
	input wire       REF_FASTER,     // ref fast
	input wire       VCO_FASTER,     // vco fast
	input wire       MAX_GAIN_HOLD,  // hold in
	input wire       MOD_CLK,        // mod clock
	input wire       RING_OSC,       // ring osc
	input wire [6:0] ROUTE_CTRL,     // route readback
	input wire       FRAC_UPDATE,    // update pulse
	input wire       OUT_LINE_ONE,   // line one
	input wire       OUT_LINE_TWO,   // line two
	input wire       OUT_LINE_THREE  // line three
);
	// lines as a bus and the route code in effect
	wire [2:0] ln  = {OUT_LINE_THREE, OUT_LINE_TWO, OUT_LINE_ONE};
	wire [3:0] sel = ROUTE_CTRL[3:0];
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// update strobe is a lone high cycle
	sequence one_pulse;
		FRAC_UPDATE ##1 !FRAC_UPDATE;
	endsequence
	a_static_value: assert property (sel == 4'h0 |-> ln == ROUTE_CTRL[6:4])
		else $error("static route mismatch");
	a_lock_route: assert property (sel == 4'h2 |-> ln == $past({PFD_UP, PFD_DN, LOCK_WINDOW}))
		else $error("lock route mismatch");
	a_slip_route: assert property (sel == 4'h3 |-> ln[2:1] == $past({REF_FASTER, VCO_FASTER}))
		else $error("slip route mismatch");
	a_hold_shown: assert property (sel == 4'h3 && $past(MAX_GAIN_HOLD, 2) |-> OUT_LINE_ONE)
		else $error("hold not shown");
	a_clock_route: assert property (sel == 4'h7 |-> ln[1:0] == $past({RING_OSC, MOD_CLK}))
		else $error("clock route mismatch");
	a_undef_low: assert property (sel inside {4'h5, 4'h8, 4'h9, [4'hB:4'hF]} |-> ln == 3'h0)
		else $error("undefined route not low");
	a_frac_single: assert property ($rose(FRAC_UPDATE) |-> one_pulse)
		else $error("update pulse too long");
	a_frac_cause: assert property (FRAC_UPDATE |-> $past(MOD_CLK) && !$past(MOD_CLK, 2))
		else $error("update pulse without clock rise");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind general_output_route_mux route_mux_properties i_props (.MCLK(MCLK), .RST(RST),
	.LOCK_WINDOW(LOCK_WINDOW), .PFD_UP(PFD_UP), .PFD_DN(PFD_DN), .REF_FASTER(REF_FASTER),
	.VCO_FASTER(VCO_FASTER), .MAX_GAIN_HOLD(MAX_GAIN_HOLD), .MOD_CLK(MOD_CLK),
	.RING_OSC(RING_OSC), .ROUTE_CTRL(ROUTE_CTRL), .FRAC_UPDATE(FRAC_UPDATE),
	.OUT_LINE_ONE(OUT_LINE_ONE), .OUT_LINE_TWO(OUT_LINE_TWO), .OUT_LINE_THREE(OUT_LINE_THREE));

/* File: tb/general_output_route_mux_test.sv */
`timescale 1ns/1ps
module general_output_route_mux_test;
	reg         clk, rst, wr, h;
	reg  [7:0]  ad;
	reg  [6:0]  wd;
	reg  [13:0] s;
	reg  [23:0] acc;
	reg  [3:0]  mo;
	reg  [2:0]  st;
	reg  [31:0] r;
	reg  [20:0] e, m;   // note: {aux, route, strobe, mask, lines}
	reg  [20:0] q[$];
	reg  [6:0]  av, ax;
	reg  [3:0]  dl;
	reg  [2:0]  dc;
	reg         pw, pm, fs, sp, at;
	wire        l1, l2, l3, fu;
	wire [6:0]  rc, xc;
	wire [2:0]  seen;
	wire        ac;
	integer     c, fail_count, checks_done;
	general_output_route_mux i_dut (.MCLK(clk), .RST(rst), .REG_WR(wr), .REG_ADDR(ad),
		.REG_WDATA(wd), .XTAL_REF(s[0]), .SINE_REF(s[1]), .REF_DIV_OUT(s[2]), .PRESC_OUT(s[3]),
		.LOCK_WINDOW(s[4]), .PFD_UP(s[5]), .PFD_DN(s[6]), .REF_FASTER(s[7]), .VCO_FASTER(s[8]),
		.MAX_GAIN_HOLD(s[9]), .LOCKED(s[10]), .MOD_CLK(s[11]), .RING_OSC(s[12]),
		.VCO_CLK(s[13]), .ACCUM(acc), .MOD_OUT(mo), .ROUTE_CTRL(rc), .AUX_CTRL(xc),
		.FRAC_UPDATE(fu), .OUT_LINE_ONE(l1), .OUT_LINE_TWO(l2), .OUT_LINE_THREE(l3));
	line_probe i_probe (.line_one(l1), .line_two(l2), .line_three(l3), .seen(seen));
	// aux clock source as the aux register picks it
	assign ac = (ax[1:0] == 2'h0) ? s[13] : (ax[1:0] == 2'h1) ? s[0] : s[12];
	////////////////////////////////////////////////////////////////////////////////
	function [31:0] lfsr(input [31:0] v);
		lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task chk(input [8*10-1:0] nm, input [6:0] got, input [6:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("[ERR] %0s exp %h seen %h", nm, exp, got);
		end
	endtask
	task finish_test;
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task wr_reg(input [7:0] a, input [6:0] d);
		@(negedge clk);
		wr = 1'b1; ad = a; wd = d;
		@(negedge clk);
		wr = 1'b0;
	endtask
	// random sources, note {aux, route, strobe, mask, lines} expected one edge on
	task step;
		@(negedge clk);
		r = lfsr(r); s = r[13:0]; acc = {r[31:16], r[7:0]}; mo = r[19:16];
		case (c)
			0: e[5:0] = {3'h7, st};
			1: e[5:0] = {3'h7, s[0], s[2], s[3]};
			2: e[5:0] = {3'h7, s[5], s[6], s[4]};
			3: e[5:0] = {3'h7, s[7], s[8], h};
			4: e[5:0] = {3'h7, s[1], s[2], fs};
			6: e[5:0] = {3'h7, acc[23:21]};
			7: e[5:0] = {3'h7, dl[ax[3:2]], s[12], s[11]};
			10: e[5:0] = {3'h7, mo[2:0]};
			default: e[5:0] = 6'h38;
		endcase
		e[20:6] = {av, st, c[3:0], pw & s[11] & ~pm};
		q.push_back(e);
		h = s[9] | (h & ~s[10]);
	endtask
	// clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// reference model of update strobe and aux clock, one step per edge
	always @(posedge clk) begin
		if (rst) begin
			pw <= 1'b0;
			pm <= 1'b0;
			fs <= 1'b0;
			sp <= 1'b0;
			at <= 1'b0;
			dc <= 3'h0;
			dl <= 4'h0;
			ax <= 7'h00;
		end else begin
			pm <= s[11];
			if (wr && ad == 8'h0C)
				pw <= 1'b1;
			else if (s[11] && !pm)
				pw <= 1'b0;
			fs <= pw & s[11] & ~pm;
			if (wr && ad == 8'h18)
				ax <= wd;
			sp <= ac;
			if (ac && !sp) begin
				if (dc >= ((ax[6:4] == 3'h7) ? 3'h6 : ax[6:4])) begin
					dc <= 3'h0;
					at <= ~at;
				end else begin
					dc <= dc + 3'h1;
				end
			end
			dl <= {dl[2:0], at};
		end
	end
	// compare oldest note once lines settle
	always @(posedge clk) begin
		#1;
		if (q.size() > 0) begin
			m = q.pop_front();
			chk("out_lines", seen & m[5:3], m[2:0]);
			chk("frac_upd", fu, m[6]);
			chk("route_ctrl", rc, m[13:7]);
			chk("aux_ctrl", xc, m[20:14]);
		end
	end
	// every route code with random sources and stray writes
	initial begin
		rst = 1'b1; wr = 1'b0; ad = 8'h00; wd = 7'h00; s = 14'h0000; acc = 24'h000000;
		mo = 4'h0; st = 3'h0; h = 1'b0; r = 32'h8973; fail_count = 0; checks_done = 0;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		for (c = 0; c < 16; c = c + 1) begin
			r = lfsr(r);
			st = r[6:4];
			av = r[14:8];
			wr_reg(8'h1B, {st, c[3:0]});
			wr_reg(8'h18, av);
			wr_reg(8'h33, r[22:16]);
			wr_reg(8'h0C, 7'h00);
			repeat (20) step;
		end
		repeat (2) @(negedge clk);
		finish_test;
	end
	// watchdog
	initial begin
		#10000;
		fail_count = fail_count + 1;
		finish_test;
	end
endmodule
